// *** include/fndc_pkg.sv ***
// fndc_pkg: constants shared by the fractional-N divider control block.
// assumes a 32-bit classic wishbone slave with byte addresses.
package fndc_pkg;

	// --------------------------------------------------------------
	// register offsets (byte addresses)
	// --------------------------------------------------------------
	localparam logic [7:0] ADR_WORD0  = 8'h00;
	localparam logic [7:0] ADR_WORD1  = 8'h04;
	localparam logic [7:0] ADR_WORD2  = 8'h08;
	localparam logic [7:0] ADR_WORD3  = 8'h0C;
	localparam logic [7:0] ADR_STATUS = 8'h10;
	localparam logic [7:0] ADR_CLEAR  = 8'h14;
	localparam logic [7:0] ADR_ENABLE = 8'h18;
	localparam logic [7:0] ADR_STATE  = 8'h1C;

	// --------------------------------------------------------------
	// reset values (word 2 keeps its always-set reserved bit)
	// --------------------------------------------------------------
	localparam logic [25:0] WORD0_RST = 26'h0000000;
	localparam logic [25:0] WORD1_RST = 26'h0000000;
	localparam logic [25:0] WORD2_RST = 26'h0080000;
	localparam logic [25:0] WORD3_RST = 26'h0000000;

	// --------------------------------------------------------------
	// field positions inside the control words
	// --------------------------------------------------------------
	localparam int LSEL_LSB = 15; // word 0, 3 bits
	localparam int RDIV_LSB = 2;  // word 2, 2 bits
	localparam int NCNT_LSB = 4;  // word 2, 10 bits
	localparam int P16_BIT  = 14; // word 2, 1 = 16/17 prescaler
	localparam int MELO_LSB = 20; // word 2, extension bits 3..0
	localparam int MEHI_LSB = 2;  // word 3, extension bits 14..4
	localparam int FN_LSB   = 13; // word 3, 8 bits

	// --------------------------------------------------------------
	// lock pin selections, status bits, counts
	// --------------------------------------------------------------
	localparam logic [2:0] SEL_LOCK = 3'h0;
	localparam logic [2:0] SEL_REF  = 3'h1;
	localparam logic [2:0] SEL_FB   = 3'h2;
	localparam logic [2:0] SEL_TEST = 3'h3;
	localparam int ST_GAIN = 0;
	localparam int ST_LOSS = 1;
	localparam logic [10:0] INT_OFFSET = 11'h003;
	localparam logic [22:0] HALF_FRAC  = 23'h400000;
	localparam logic [4:0]  LOCK_CNT   = 5'h10;

	// byte-lane merge of a wishbone write
	function automatic logic [31:0] fndc_bytewr(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

// *** rtl/fndc_sync.sv ***
// fndc_sync: two-flop synchroniser for asynchronous pin levels.
// assumes inputs are slow levels relative to sys_clk.
`timescale 1ns/10ps
module fndc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	// pins and synchronised copy
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule

// *** rtl/fndc_refdiv.sv ***
// fndc_refdiv: reference divider, three cascaded halving stages.
// assumes ref_edge is a one-cycle pulse per reference rising edge.
`timescale 1ns/10ps
module fndc_refdiv (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// reference in
	input  wire logic       ref_edge,
	input  wire logic       ref_level,
	input  wire logic [1:0] rdiv,
	// divided reference out
	output logic            ref_tick,
	output logic            div_level
);

	logic [2:0] stage_q;
	logic [2:0] mask_w;

	// each bit toggles when all lower stages are high: a ripple of /2
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			stage_q <= 3'h0;
		end else if (ref_edge) begin
			stage_q <= stage_q + 3'h1;
		end
	end

	// selector: pick /1, /2, /4 or /8
	assign mask_w    = (rdiv == 2'h0) ? 3'h0 : (rdiv == 2'h1) ? 3'h1 :
	                   (rdiv == 2'h2) ? 3'h3 : 3'h7;
	assign ref_tick  = ref_edge & ((stage_q & mask_w) == mask_w);
	assign div_level = (rdiv == 2'h0) ? ref_level : stage_q[rdiv - 2'h1];

endmodule

// *** rtl/fndc_top.sv ***
// fndc_top: divider and selection logic of a fractional-N synthesizer.
// assumes a classic wishbone master, prescaler output and reference
// as asynchronous pins, all sampled on sys_clk (40 MHz).
`timescale 1ns/10ps
module fndc_top (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// device pins
	input  wire logic        ref_in,
	input  wire logic        presc_in,
	input  wire logic        output_switch_enable,
	output logic             lock_indicator_pin,
	output logic             synth_output_en,
	// prescaler control
	output logic             presc_modulus,
	output logic             presc_div16,
	// interrupt
	output logic             irq
);

	// ------------------------------------------------------------
	// pin sampling
	// ------------------------------------------------------------
	logic [2:0]  pin_s;
	logic [1:0]  prev_q;
	logic        ref_edge;
	logic        presc_edge;
	logic        ref_tick;
	logic        ref_level;

	fndc_sync #(.W(3)) u_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.async_i ({output_switch_enable, presc_in, ref_in}),
		.sync_o  (pin_s)
	);

	// delayed copy for edge detection, taken after the synchroniser
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prev_q <= 2'h0;
		end else begin
			prev_q <= pin_s[1:0];
		end
	end

	assign ref_edge   = pin_s[0] & ~prev_q[0];
	assign presc_edge = pin_s[1] & ~prev_q[1];

	// ------------------------------------------------------------
	// control words and interrupt registers
	// ------------------------------------------------------------
	logic [25:0] word0_q;
	logic [25:0] word1_q;
	logic [25:0] word2_q;
	logic [25:0] word3_q;
	logic [1:0]  status_q;
	logic [1:0]  enable_q;
	logic        ack_q;
	logic [31:0] rdat_q;

	// field extraction
	logic [2:0]  lsel_w;
	logic [1:0]  rdiv_w;
	logic [9:0]  nprog_w;
	logic        p16_w;
	logic [7:0]  fn_w;
	logic [14:0] me_w;
	logic [22:0] frac_w;

	assign lsel_w  = word0_q[fndc_pkg::LSEL_LSB +: 3];
	assign rdiv_w  = word2_q[fndc_pkg::RDIV_LSB +: 2];
	assign nprog_w = word2_q[fndc_pkg::NCNT_LSB +: 10];
	assign p16_w   = word2_q[fndc_pkg::P16_BIT];
	assign fn_w    = word3_q[fndc_pkg::FN_LSB +: 8];
	assign me_w    = {word3_q[fndc_pkg::MEHI_LSB +: 11],
	                  word2_q[fndc_pkg::MELO_LSB +: 4]};
	// code bits weigh 2^-1..2^-8, extension 2^-9..2^-23
	assign frac_w  = {fn_w, me_w};

	// ------------------------------------------------------------
	// reference divider
	// ------------------------------------------------------------
	fndc_refdiv u_refdiv (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.ref_edge  (ref_edge),
		.ref_level (pin_s[0]),
		.rdiv      (rdiv_w),
		.ref_tick  (ref_tick),
		.div_level (ref_level)
	);

	// ------------------------------------------------------------
	// modulated divider
	// ------------------------------------------------------------
	logic [7:0]  main_cnt_q;
	logic [3:0]  swallow_cnt_q;
	logic [22:0] acc_q;
	logic        carry_q;
	logic        fb_level_q;
	logic        p16_run_q;
	logic [9:0]  n_int_w;
	logic [24:0] acc_sum_w;
	logic [10:0] total_w;
	logic [7:0]  load_main_w;
	logic [3:0]  load_swal_w;
	logic        fb_tick;

	// integer count; 8/9 mode drops the top swallow bit
	assign n_int_w = p16_w ? nprog_w :
	                 {1'b0, nprog_w[9:4], nprog_w[2:0]};
	// accumulator with a constant half: gives the extra 0.5 of the offset
	assign acc_sum_w = {2'h0, acc_q} + {2'h0, frac_w} +
	                   {2'h0, fndc_pkg::HALF_FRAC};
	assign total_w = {1'b0, n_int_w} + fndc_pkg::INT_OFFSET +
	                 {9'h000, acc_sum_w[24:23]};
	assign load_main_w = p16_w ? {1'b0, total_w[10:4]} : total_w[10:3];
	assign load_swal_w = p16_w ? total_w[3:0] : {1'b0, total_w[2:0]};
	assign fb_tick = presc_edge & (main_cnt_q == 8'h01);

	// counters load only at the end of a period, so a bus write never
	// splits a period between old and new settings
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			main_cnt_q    <= 8'h01;
			swallow_cnt_q <= 4'h0;
			presc_modulus <= 1'b0;
			acc_q         <= 23'h000000;
			carry_q       <= 1'b0;
			fb_level_q    <= 1'b0;
			p16_run_q     <= 1'b0;
		end else if (fb_tick) begin
			main_cnt_q    <= load_main_w;
			swallow_cnt_q <= load_swal_w;
			presc_modulus <= (load_swal_w != 4'h0);
			acc_q         <= acc_sum_w[22:0];
			carry_q       <= |acc_sum_w[24:23];
			fb_level_q    <= ~fb_level_q;
			p16_run_q     <= p16_w;
		end else if (presc_edge) begin
			// swallow edges run at the upper ratio, the rest at the lower
			main_cnt_q <= main_cnt_q - 8'h01;
			if (swallow_cnt_q != 4'h0) begin
				swallow_cnt_q <= swallow_cnt_q - 4'h1;
			end
			presc_modulus <= (swallow_cnt_q > 4'h1);
		end
	end

	assign presc_div16 = p16_run_q;

	// ------------------------------------------------------------
	// lock detection: one feedback period per comparison period
	// ------------------------------------------------------------
	logic [1:0]  fb_seen_q;
	logic [4:0]  lock_cnt_q;
	logic        lock_prev_q;
	logic [1:0]  seen_now_w;
	logic        lock_w;

	assign seen_now_w = fb_seen_q + {1'b0, fb_tick};
	assign lock_w     = (lock_cnt_q == fndc_pkg::LOCK_CNT);

	// a run of matched periods declares lock; one miss drops it
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			fb_seen_q   <= 2'h0;
			lock_cnt_q  <= 5'h00;
			lock_prev_q <= 1'b0;
		end else begin
			lock_prev_q <= lock_w;
			if (ref_tick) begin
				fb_seen_q <= 2'h0;
				if (seen_now_w != 2'h1) begin
					lock_cnt_q <= 5'h00;
				end else if (!lock_w) begin
					lock_cnt_q <= lock_cnt_q + 5'h01;
				end
			end else if (fb_seen_q != 2'h2) begin
				fb_seen_q <= seen_now_w;
			end
		end
	end

	// ------------------------------------------------------------
	// pin outputs
	// ------------------------------------------------------------
	logic        pin_mux_w;

	assign pin_mux_w = (lsel_w == fndc_pkg::SEL_LOCK) ? lock_w :
	                   (lsel_w == fndc_pkg::SEL_REF)  ? ref_level :
	                   (lsel_w == fndc_pkg::SEL_FB)   ? fb_level_q :
	                   (lsel_w == fndc_pkg::SEL_TEST) ? carry_q : 1'b0;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lock_indicator_pin <= 1'b0;
			synth_output_en    <= 1'b0;
		end else begin
			lock_indicator_pin <= pin_mux_w;
			synth_output_en    <= pin_s[2];
		end
	end

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	logic        req_w;
	logic        wr_w;
	logic [1:0]  evt_w;
	logic [1:0]  clr_w;
	logic [31:0] rd_w;

	assign req_w = wb_cyc_i & wb_stb_i;
	assign wr_w  = req_w & wb_we_i & ack_q; // commit on the acked edge
	assign evt_w = {~lock_w & lock_prev_q, lock_w & ~lock_prev_q};
	assign clr_w = (wr_w && wb_adr_i == fndc_pkg::ADR_CLEAR && wb_sel_i[0])
	               ? wb_dat_i[1:0] : 2'h0;

	// read mux; unmapped reads return zero
	always_comb begin
		rd_w = 32'h00000000;
		if (wb_adr_i == fndc_pkg::ADR_WORD0) begin
			rd_w = {6'h00, word0_q};
		end else if (wb_adr_i == fndc_pkg::ADR_WORD1) begin
			rd_w = {6'h00, word1_q};
		end else if (wb_adr_i == fndc_pkg::ADR_WORD2) begin
			rd_w = {6'h00, word2_q};
		end else if (wb_adr_i == fndc_pkg::ADR_WORD3) begin
			rd_w = {6'h00, word3_q};
		end else if (wb_adr_i == fndc_pkg::ADR_STATUS) begin
			rd_w = {30'h00000000, status_q};
		end else if (wb_adr_i == fndc_pkg::ADR_ENABLE) begin
			rd_w = {30'h00000000, enable_q};
		end else if (wb_adr_i == fndc_pkg::ADR_STATE) begin
			rd_w = {14'h0000, synth_output_en, presc_modulus,
			        swallow_cnt_q, main_cnt_q, 3'h0, lock_w};
		end
	end

	// handshake: ack one cycle after the request, dropped the next
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			ack_q <= req_w & ~ack_q;
			if (req_w && !ack_q) begin
				rdat_q <= rd_w;
			end
		end
	end

	// register writes, byte lanes honoured
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			word0_q  <= fndc_pkg::WORD0_RST;
			word1_q  <= fndc_pkg::WORD1_RST;
			word2_q  <= fndc_pkg::WORD2_RST;
			word3_q  <= fndc_pkg::WORD3_RST;
			enable_q <= 2'h0;
		end else if (wr_w) begin
			if (wb_adr_i == fndc_pkg::ADR_WORD0) begin
				word0_q <= 26'(fndc_pkg::fndc_bytewr({6'h00, word0_q},
					wb_dat_i, wb_sel_i));
			end else if (wb_adr_i == fndc_pkg::ADR_WORD1) begin
				word1_q <= 26'(fndc_pkg::fndc_bytewr({6'h00, word1_q},
					wb_dat_i, wb_sel_i));
			end else if (wb_adr_i == fndc_pkg::ADR_WORD2) begin
				word2_q <= 26'(fndc_pkg::fndc_bytewr({6'h00, word2_q},
					wb_dat_i, wb_sel_i));
			end else if (wb_adr_i == fndc_pkg::ADR_WORD3) begin
				word3_q <= 26'(fndc_pkg::fndc_bytewr({6'h00, word3_q},
					wb_dat_i, wb_sel_i));
			end else if (wb_adr_i == fndc_pkg::ADR_ENABLE && wb_sel_i[0]) begin
				enable_q <= wb_dat_i[1:0];
			end
		end
	end

	// sticky status: a new event beats a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			status_q <= 2'h0;
			irq      <= 1'b0;
		end else begin
			status_q <= (status_q & ~clr_w) | evt_w;
			irq      <= |(status_q & enable_q);
		end
	end

	assign wb_dat_o = rdat_q;
	assign wb_ack_o = ack_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [11:0] vco_acc_q;
	logic [11:0] period_q;
	logic        primed_q;
	logic [11:0] ratio_w;

	assign ratio_w = p16_run_q ? (presc_modulus ? 12'h011 : 12'h010) :
	                 (presc_modulus ? 12'h009 : 12'h008);

	// oscillator cycles per feedback period, for the period check
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			vco_acc_q <= 12'h000;
			period_q  <= 12'h000;
			primed_q  <= 1'b0;
		end else if (fb_tick) begin
			vco_acc_q <= 12'h000;
			period_q  <= {1'b0, total_w};
			primed_q  <= (load_main_w != 8'h00); // zero main is illegal
		end else if (presc_edge) begin
			vco_acc_q <= vco_acc_q + ratio_w;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_sw_high;
		output_switch_enable [*4];
	endsequence
	sequence s_sw_low;
		!output_switch_enable [*4];
	endsequence

	a_lock_select: assert property (
		lsel_w == fndc_pkg::SEL_LOCK |=> lock_indicator_pin == $past(lock_w))
		else $error("lock pin does not follow lock state");
	a_ref_select: assert property (
		lsel_w == fndc_pkg::SEL_REF |=> lock_indicator_pin == $past(ref_level))
		else $error("lock pin does not follow divided reference");
	a_refdiv_eight: assert property (
		ref_tick && rdiv_w == 2'h3 |=> !ref_tick [*7])
		else $error("divide by eight ticks too often");
	a_switch_on: assert property (
		s_sw_high |=> synth_output_en)
		else $error("output not passed with switch enabled");
	a_switch_off: assert property (
		s_sw_low |=> !synth_output_en)
		else $error("output not blocked with switch disabled");
	a_period_len: assert property (
		fb_tick && primed_q |-> vco_acc_q + ratio_w == period_q)
		else $error("feedback period length wrong");
	a_swallow_p8: assert property (
		fb_tick && !p16_w |=> swallow_cnt_q < 4'h8)
		else $error("swallow count uses fourth bit in 8/9 mode");
	a_swallow_mod: assert property (
		presc_modulus |-> swallow_cnt_q != 4'h0)
		else $error("upper ratio without swallow count");
	a_reload_hold: assert property (
		!presc_edge |=> $stable(main_cnt_q) && $stable(swallow_cnt_q))
		else $error("counters changed outside a prescaler edge");
	a_status_set: assert property (
		evt_w[0] |=> status_q[0])
		else $error("lock event lost against clear");

endmodule

// *** testbench/fndc_presc_model.sv ***
// fndc_presc_model: behavioural dual-modulus prescaler behind the vco.
// assumes presc_modulus and presc_div16 come from the block under test.
`timescale 1ns/10ps
module fndc_presc_model (
	// clock
	input  wire logic        sys_clk,
	// ratio control from the block
	input  wire logic        presc_modulus,
	input  wire logic        presc_div16,
	// prescaler pin and running tally of vco cycles
	output logic             presc_out,
	output logic [31:0]      vco_count
);
	logic [1:0] ph_q;

	initial begin
		ph_q = 2'h0;
		presc_out = 1'b0;
		vco_count = 32'h0;
	end

	// --------------------------------------------------------------
	// one prescaler cycle per four sys_clk periods
	// --------------------------------------------------------------
	// the vco runs free, so the pin toggles outside lock as well;
	// the ratio of the cycle just ending is booked one sys_clk before its rising edge
	always @(posedge sys_clk) begin
		ph_q <= ph_q + 2'h1;
		presc_out <= ph_q[0] ^ ph_q[1];
		if (ph_q == 2'h0) begin
			vco_count <= vco_count + (presc_div16 ? 32'h10 : 32'h8)
				+ {31'h0, presc_modulus};
		end
	end
endmodule

// *** testbench/fndc_top_tb_top.sv ***
// fndc_top_tb_top: self-checking bench for the divider control block.
// assumes fndc_pkg, the design files and the prescaler model.
`timescale 1ns/10ps
module fndc_top_tb_top;
	logic        sys_clk;
	logic        sys_rst;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        ref_in;
	logic        presc_in;
	logic        output_switch_enable;
	logic        lock_indicator_pin;
	logic        synth_output_en;
	logic        presc_modulus;
	logic        presc_div16;
	logic        irq;
	logic [31:0] vco_count;
	logic [31:0] rdat;
	logic [31:0] shadow [4];
	logic [31:0] r;
	int          seed;
	int          n_fail;
	int          check_count;
	int          ref_half;
	int          ref_cnt;
	int          c;

	fndc_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_in(ref_in),
		.presc_in(presc_in), .output_switch_enable(output_switch_enable),
		.lock_indicator_pin(lock_indicator_pin),
		.synth_output_en(synth_output_en), .presc_modulus(presc_modulus),
		.presc_div16(presc_div16), .irq(irq));

	fndc_presc_model u_presc (.sys_clk(sys_clk),
		.presc_modulus(presc_modulus), .presc_div16(presc_div16),
		.presc_out(presc_in), .vco_count(vco_count));

	// --------------------------------------------------------------
	// clock, reference pin, watchdog
	// --------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// reference half period in sys_clk cycles, set by the tests
	always @(posedge sys_clk) begin
		if (ref_cnt >= ref_half - 1) begin
			ref_cnt <= 0;
			ref_in <= ~ref_in;
		end else begin
			ref_cnt <= ref_cnt + 1;
		end
	end

	// a hang costs one mismatch and ends the run the normal way
	initial begin
		repeat (90000) @(posedge sys_clk);
		n_fail++;
		wrap_up();
	end

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	// one classic cycle; request held until ack is seen at a rising edge
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] dat, input logic [3:0] sel);
		@(posedge sys_clk);
		chk({31'h0, wb_ack_o}, 32'h0); // ack gone one cycle after it
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		@(posedge sys_clk);
		while (wb_ack_o !== 1'b1) begin
			@(posedge sys_clk);
		end
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	function automatic logic [31:0] lanes(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	function automatic logic [31:0] w2(input logic p16,
		input logic [9:0] n, input logic [14:0] me, input logic [1:0] rd);
		return 32'(fndc_pkg::WORD2_RST) | (32'(me[3:0]) << fndc_pkg::MELO_LSB)
			| (32'(p16) << fndc_pkg::P16_BIT) | (32'(n) << fndc_pkg::NCNT_LSB)
			| (32'(rd) << fndc_pkg::RDIV_LSB);
	endfunction

	function automatic logic [31:0] w3(input logic [7:0] fn,
		input logic [14:0] me);
		return (32'(fn) << fndc_pkg::FN_LSB)
			| (32'(me[14:4]) << fndc_pkg::MEHI_LSB);
	endfunction

	// cycles until the lock pin changes level
	task automatic wait_tog(output int n);
		logic old;
		n = 0;
		old = lock_indicator_pin;
		while (lock_indicator_pin === old && n < 4000) begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	task automatic wait_pin(input logic v);
		int n;
		n = 0;
		while (lock_indicator_pin !== v && n < 12000) begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	// vco cycles over k feedback periods against the ratio formula
	task automatic fb_case(input logic p16, input logic [9:0] n,
		input logic [7:0] fn, input logic [14:0] me, input int k);
		logic [47:0] acc;
		logic [31:0] lo;
		logic [31:0] got;
		acc = 48'(k) * (48'({fn, me}) + 48'h400000);
		lo = p16 ? 32'(n) : 32'(n[9:4]) * 8 + 32'(n[2:0]);
		lo = 32'(k) * (lo + 3) + 32'(acc >> 23);
		wb(1'b1, fndc_pkg::ADR_WORD3, w3(fn, me), 4'hF);
		wb(1'b1, fndc_pkg::ADR_WORD2, w2(p16, n, me, 2'h0), 4'hF);
		wait_tog(c);
		wait_tog(c);
		got = vco_count;
		repeat (k) wait_tog(c);
		got = vco_count - got;
		// accumulator start phase may add one carry when not exact
		if (acc[22:0] != 23'h0 && got == lo + 1) begin
			got = lo;
		end
		chk(got, lo);
		$display("test fb_case done");
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		seed = 32'h51221C48;
		n_fail = 0;
		check_count = 0;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		ref_in = 1'b0;
		ref_cnt = 0;
		ref_half = 4;
		output_switch_enable = 1'b0;
		sys_rst = 1'b1;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// reset values, unmapped and read-only places
		shadow = '{32'(fndc_pkg::WORD0_RST), 32'(fndc_pkg::WORD1_RST),
			32'(fndc_pkg::WORD2_RST), 32'(fndc_pkg::WORD3_RST)};
		for (int i = 0; i < 4; i++) begin
			wb(1'b0, 8'(i * 4), 32'h0, 4'hF);
			chk(rdat, shadow[i]);
		end
		wb(1'b1, fndc_pkg::ADR_STATUS, 32'hFFFFFFFF, 4'hF);
		wb(1'b0, fndc_pkg::ADR_STATUS, 32'h0, 4'hF);
		chk(rdat, 32'h0);
		wb(1'b0, 8'h40, 32'h0, 4'hF);
		chk(rdat, 32'h0);
		// random lane writes to words 0, 1 and 3
		for (int i = 0; i < 12; i++) begin
			r = $random(seed);
			c = (r[1:0] == 2'h2) ? 3 : int'(r[1:0] & 2'h1);
			r = $random(seed);
			wb(1'b1, 8'(c * 4), r, r[31:28]);
			shadow[c] = ((shadow[c] & ~lanes(r[31:28])) |
				(r & lanes(r[31:28]))) & 32'h03FFFFFF;
			wb(1'b0, 8'(c * 4), 32'h0, 4'hF);
			chk(rdat, shadow[c]);
		end
		$display("test registers done");
		// switch enable follows the pin after the synchroniser
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			@(posedge sys_clk);
			output_switch_enable <= r[0];
			repeat (4) @(posedge sys_clk);
			@(negedge sys_clk);
			chk({31'h0, synth_output_en}, {31'h0, r[0]});
		end
		$display("test switch done");
		// divided reference on the pin, 5 MHz in stays below limit
		wb(1'b1, fndc_pkg::ADR_WORD0,
			32'(fndc_pkg::SEL_REF) << fndc_pkg::LSEL_LSB, 4'hF);
		for (int rd = 0; rd < 4; rd++) begin
			wb(1'b1, fndc_pkg::ADR_WORD2, w2(0, 10'h070, 0, 2'(rd)), 4'hF);
			wait_tog(c);
			wait_tog(c);
			wait_tog(c);
			r = 32'(c);
			wait_tog(c);
			chk(r + 32'(c), 32'(8 << rd));
		end
		wb(1'b1, fndc_pkg::ADR_WORD0, 32'h5 << fndc_pkg::LSEL_LSB, 4'hF);
		repeat (6) @(negedge sys_clk);
		chk({31'h0, lock_indicator_pin}, 32'h0);
		$display("test refdiv done");
		// feedback divider: both prescalers, fourth swallow bit unused
		wb(1'b1, fndc_pkg::ADR_WORD0,
			32'(fndc_pkg::SEL_FB) << fndc_pkg::LSEL_LSB, 4'hF);
		fb_case(1'b0, 10'h0F7, 8'h00, 15'h0000, 2);
		fb_case(1'b0, 10'h0FF, 8'h00, 15'h0000, 2);
		fb_case(1'b1, 10'h0F0, 8'h80, 15'h0000, 2);
		fb_case(1'b0, 10'h070, 8'h40, 15'h0000, 4);
		r = $random(seed);
		fb_case(1'b0, {6'(7 + r[1:0]), r[5:2]},
			r[13:6], r[28:14], 64);
		// lock: 240-cycle reference tick against 60 x 4 feedback period
		ref_half = 15;
		wb(1'b1, fndc_pkg::ADR_WORD0, 32'h0, 4'hF);
		wb(1'b1, fndc_pkg::ADR_WORD3, w3(8'h80, 15'h0), 4'hF);
		wb(1'b1, fndc_pkg::ADR_WORD2, w2(0, 10'h3B5, 0, 2'h3), 4'hF);
		wb(1'b1, fndc_pkg::ADR_CLEAR, 32'h3, 4'hF);
		wb(1'b1, fndc_pkg::ADR_ENABLE, 32'h1, 4'hF);
		wait_pin(1'b1);
		chk({31'h0, lock_indicator_pin}, 32'h1);
		wb(1'b0, fndc_pkg::ADR_STATE, 32'h0, 4'hF);
		chk(rdat & 32'h1, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, fndc_pkg::ADR_ENABLE, 32'h2, 4'hF);
		repeat (2) @(negedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		ref_half = 10;
		wait_pin(1'b0);
		chk({31'h0, lock_indicator_pin}, 32'h0);
		repeat (2) @(negedge sys_clk);
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, fndc_pkg::ADR_CLEAR, 32'h2, 4'hF);
		wb(1'b0, fndc_pkg::ADR_STATUS, 32'h0, 4'hF);
		chk(rdat, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wb(1'b0, fndc_pkg::ADR_CLEAR, 32'h0, 4'hF);
		chk(rdat, 32'h0);
		$display("test lock done");
		wrap_up();
	end
endmodule
